// *** hw/nfc_pkg.sv ***
package nfc_pkg;
  // register word indices, byte address is index times four
  localparam logic [2:0] R_CMD = 3'h0;
  localparam logic [2:0] R_CTRL = 3'h1;
  localparam logic [2:0] R_COL = 3'h2;
  localparam logic [2:0] R_ROW = 3'h3;
  localparam logic [2:0] R_DATA = 3'h4;
  localparam logic [2:0] R_STAT = 3'h5;
  localparam logic [2:0] R_BAD = 3'h6;
  // control fields
  localparam int CF_WP = 0;
  localparam int CF_PLANE = 1;
  // status fields
  localparam int SF_BUSY = 0;
  localparam int SF_FAIL = 1;
  localparam int SF_REF = 2;
  localparam int SF_NOTFF = 3;
  localparam int SF_RB = 4;
  localparam int SF_PWR = 5;
  localparam int SF_PEND = 6;
  localparam int SF_SBYTE = 8;
  localparam int SF_PAR = 16;
  // operations written to the command register
  localparam logic [2:0] OP_RST = 3'h0;
  localparam logic [2:0] OP_PRD = 3'h1;
  localparam logic [2:0] OP_RDB = 3'h2;
  localparam logic [2:0] OP_WRB = 3'h3;
  localparam logic [2:0] OP_PCF = 3'h4;
  localparam logic [2:0] OP_ERS = 3'h5;
  localparam logic [2:0] OP_STS = 3'h6;
  localparam logic [2:0] OP_PST = 3'h7;
  // sequence item kinds
  localparam logic [2:0] K_CMD = 3'h0;
  localparam logic [2:0] K_ADR = 3'h1;
  localparam logic [2:0] K_DWR = 3'h2;
  localparam logic [2:0] K_DRD = 3'h3;
  localparam logic [2:0] K_WRB = 3'h4;
  localparam logic [2:0] K_END = 3'h5;
  localparam logic [2:0] K_NOP = 3'h6;
  // flash command bytes
  localparam logic [7:0] C_READ1 = 8'h00;
  localparam logic [7:0] C_READ2 = 8'h30;
  localparam logic [7:0] C_ERS1 = 8'h60;
  localparam logic [7:0] C_ERS2 = 8'hd0;
  localparam logic [7:0] C_PROG1 = 8'h80;
  localparam logic [7:0] C_PROG1B = 8'h81;
  localparam logic [7:0] C_PROG2 = 8'h10;
  localparam logic [7:0] C_PLANE = 8'h11;
  localparam logic [7:0] C_STAT = 8'h70;
  localparam logic [7:0] C_RESET = 8'hff;
  localparam int SB_FAIL = 0;
  localparam int SB_RDY = 6;
  localparam logic [7:0] ERASED = 8'hff;
  // address layout
  localparam int COL_W = 12;
  localparam int ROW_W = 17;
  localparam int BLK_LSB = 6;
  localparam int BLK_W = 11;
  localparam int BBT_DEPTH = 8;
  // timing
  localparam int CLK_NS = 4;
  localparam int T_CLS_NS = 12;
  localparam int T_WP_NS = 12;
  localparam int T_WH_NS = 10;
  localparam int T_ADL_NS = 70;
  localparam int T_REA_NS = 20;
  localparam int T_RHW_NS = 100;
  localparam int T_WB_NS = 100;
  localparam int T_RR_NS = 20;
  localparam int T_PWR_US = 100;
  localparam int SYNC_CYC = 2;
  localparam int SET_CYC = (T_CLS_NS + CLK_NS - 1) / CLK_NS;
  localparam int WP_CYC = (T_WP_NS + CLK_NS - 1) / CLK_NS;
  localparam int WH_CYC = (T_WH_NS + CLK_NS - 1) / CLK_NS;
  localparam int ADL_CYC = (T_ADL_NS + CLK_NS - 1) / CLK_NS;
  localparam int RDL_CYC = (T_REA_NS + CLK_NS - 1) / CLK_NS + SYNC_CYC;
  localparam int RHW_CYC = (T_RHW_NS + CLK_NS - 1) / CLK_NS;
  localparam int WB_CYC = (T_WB_NS + CLK_NS - 1) / CLK_NS;
  localparam int RR_CYC = (T_RR_NS + CLK_NS - 1) / CLK_NS;
  localparam int PWR_CYC = (T_PWR_US * 1000 + CLK_NS - 1) / CLK_NS;
  typedef enum logic [2:0] {
    st_pwr = 3'b000,
    st_idle = 3'b001,
    st_fetch = 3'b010,
    st_set = 3'b011,
    st_low = 3'b100,
    st_high = 3'b101,
    st_busy = 3'b110,
    st_rr = 3'b111
  } nfc_st_e;
endpackage

// *** hw/nfc_bbt.sv ***
`timescale 1ns/10ps
module nfc_bbt #(
  parameter int DEPTH = 8,
  parameter int BW = 11
) (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic add_i,
  input wire logic [BW-1:0] add_blk_i,
  input wire logic [BW-1:0] chk_blk_i,
  output logic hit_o,
  output logic [$clog2(DEPTH+1)-1:0] cnt_o
);
  localparam int CW = $clog2(DEPTH + 1);
  generate
    if (DEPTH < 1 || BW < 1) begin : g_chk
      $error("nfc_bbt: bad parameter");
    end
  endgenerate
  logic [BW-1:0] blk_ff [DEPTH];
  logic [DEPTH-1:0] vld_ff;
  logic [DEPTH-1:0] hit_v;
  logic [DEPTH-1:0] dup_v;
  logic [CW-1:0] cnt_ff;
  wire full = (cnt_ff == CW'(DEPTH));
  wire do_add = add_i & ~(|dup_v) & ~full;
  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi++) begin : g_ent
      assign hit_v[gi] = vld_ff[gi] & (blk_ff[gi] == chk_blk_i);
      assign dup_v[gi] = vld_ff[gi] & (blk_ff[gi] == add_blk_i);
      always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
          vld_ff[gi] <= 1'b0;
          blk_ff[gi] <= '0;
        end else if (do_add && cnt_ff == CW'(gi)) begin
          vld_ff[gi] <= 1'b1;
          blk_ff[gi] <= add_blk_i;
        end
      end
    end
  endgenerate
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      cnt_ff <= '0;
    end else if (do_add) begin
      cnt_ff <= cnt_ff + CW'(1);
    end
  end
  assign hit_o = |hit_v;
  assign cnt_o = cnt_ff;
endmodule // nfc_bbt

// *** hw/nfc_host.sv ***
// Implementation choices: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/10ps
module nfc_host #(
  parameter int PWR_CYC = nfc_pkg::PWR_CYC,
  parameter int BBT_DEPTH = nfc_pkg::BBT_DEPTH
) (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic [4:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic nand_ce_b_o,
  output logic nand_cle_o,
  output logic nand_ale_o,
  output logic nand_we_b_o,
  output logic read_strobe_low_o,
  output logic nand_wp_b_o,
  input wire logic nand_rb_i,
  input wire logic [7:0] nand_dq_i,
  output logic [7:0] nand_dq_o,
  output logic nand_dq_oe_b_o
);
  localparam int PW = $clog2(PWR_CYC + 1);
  generate
    if (PWR_CYC < 2 || BBT_DEPTH < 1) begin : g_chk
      $error("nfc_host: bad parameter");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // address bytes and per-operation sequences
  function automatic logic [7:0] abyte(input logic [2:0] idx, input logic [11:0] col,
                                       input logic [16:0] row);
    case (idx)
      3'h0: abyte = col[7:0];
      3'h1: abyte = {4'h0, col[11:8]};
      3'h2: abyte = row[7:0];
      3'h3: abyte = row[15:8];
      default: abyte = {7'h00, row[16]};
    endcase
  endfunction

  function automatic logic [10:0] item(input logic [2:0] op, input logic [3:0] stp,
                                       input logic [11:0] col, input logic [16:0] row,
                                       input logic sm, input logic two, input logic [7:0] wd);
    logic [2:0] ai;
    ai = stp[2:0] - 3'h1;
    item = {nfc_pkg::K_END, 8'h00};
    case (op)
      nfc_pkg::OP_RST: begin
        if (stp == 4'h0) item = {nfc_pkg::K_CMD, nfc_pkg::C_RESET};
        else if (stp == 4'h1) item = {nfc_pkg::K_WRB, 8'h00};
      end
      nfc_pkg::OP_PRD: begin
        if (stp == 4'h0) item = {nfc_pkg::K_CMD, nfc_pkg::C_READ1};
        else if (stp <= 4'h5) item = {nfc_pkg::K_ADR, abyte(ai, col, row)};
        else if (stp == 4'h6) item = {nfc_pkg::K_CMD, nfc_pkg::C_READ2};
        else if (stp == 4'h7) item = {nfc_pkg::K_WRB, 8'h00};
      end
      nfc_pkg::OP_RDB: begin
        // leave status mode before serial data out
        if (stp == 4'h0) item = sm ? {nfc_pkg::K_CMD, nfc_pkg::C_READ1} : {nfc_pkg::K_NOP, 8'h00};
        else if (stp == 4'h1) item = {nfc_pkg::K_DRD, 8'h00};
      end
      nfc_pkg::OP_WRB: begin
        if (stp == 4'h0) item = {nfc_pkg::K_DWR, wd};
      end
      nfc_pkg::OP_PST: begin
        if (stp == 4'h0) item = {nfc_pkg::K_CMD, two ? nfc_pkg::C_PROG1B : nfc_pkg::C_PROG1};
        else if (stp <= 4'h5) item = {nfc_pkg::K_ADR, abyte(ai, col, row)};
      end
      nfc_pkg::OP_PCF: begin
        if (stp == 4'h0) item = {nfc_pkg::K_CMD, two ? nfc_pkg::C_PLANE : nfc_pkg::C_PROG2};
        else if (stp == 4'h1) item = {nfc_pkg::K_WRB, 8'h00};
        else if (stp == 4'h2 && !two) item = {nfc_pkg::K_CMD, nfc_pkg::C_STAT};
        else if (stp == 4'h3 && !two) item = {nfc_pkg::K_DRD, 8'h00};
      end
      nfc_pkg::OP_ERS: begin
        if (stp == 4'h0) item = {nfc_pkg::K_CMD, nfc_pkg::C_ERS1};
        else if (stp <= 4'h3) item = {nfc_pkg::K_ADR, abyte(ai + 3'h2, col, row)};
        else if (stp == 4'h4) item = {nfc_pkg::K_CMD, nfc_pkg::C_ERS2};
        else if (stp == 4'h5) item = {nfc_pkg::K_WRB, 8'h00};
        else if (stp == 4'h6) item = {nfc_pkg::K_CMD, nfc_pkg::C_STAT};
        else if (stp == 4'h7) item = {nfc_pkg::K_DRD, 8'h00};
      end
      nfc_pkg::OP_STS: begin
        if (stp == 4'h0) item = {nfc_pkg::K_CMD, nfc_pkg::C_STAT};
        else if (stp == 4'h1) item = {nfc_pkg::K_DRD, 8'h00};
      end
      default: item = {nfc_pkg::K_END, 8'h00};
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state
  nfc_pkg::nfc_st_e st_ff, nxt_st;
  logic [7:0] cnt_ff, nxt_cnt;
  logic [3:0] step_ff, nxt_step;
  logic [2:0] kind_ff, nxt_kind;
  logic ce_b_ff, nxt_ce_b, cle_ff, nxt_cle, ale_ff, nxt_ale;
  logic we_b_ff, nxt_we_b, rd_b_ff, nxt_rd_b, oe_b_ff, nxt_oe_b;
  logic [7:0] dq_ff, nxt_dq;
  logic cap;
  logic [PW-1:0] pwr_cnt_ff;
  logic pwr_done_ff;
  logic rb_s1_ff, rb_s2_ff;
  logic [7:0] dq_s1_ff, dq_s2_ff;
  logic wp_rel_ff, plane_sel_ff, two_ff, pend_ff, stat_mode_ff;
  logic fail_ff, refused_ff, not_ff_ff;
  logic [nfc_pkg::COL_W-1:0] col_ff;
  logic [nfc_pkg::ROW_W-1:0] row_ff;
  logic [7:0] wdat_ff, rdat_ff, sbyte_ff, par_ff;
  logic [2:0] op_ff;
  logic last_vld_ff;
  logic [nfc_pkg::BLK_W-1:0] last_blk_ff;
  logic [nfc_pkg::BLK_LSB-1:0] last_pg_ff;
  logic rd_vld_ff;
  logic [31:0] rdata_ff, sts_w;
  logic bbt_hit;
  logic [$clog2(BBT_DEPTH+1)-1:0] bbt_cnt;

  ////////////////////////////////////////////////////////////////////////////
  // register decode
  wire [2:0] widx = avs_address_i[4:2];
  wire wr_ok = avs_write_i & avs_byteenable_i[0];
  wire idle = (st_ff == nfc_pkg::st_idle);
  wire [2:0] op_w = avs_writedata_i[2:0];
  wire cmd_acc = wr_ok & idle & (widx == nfc_pkg::R_CMD);
  wire [nfc_pkg::BLK_W-1:0] blk_w = row_ff[nfc_pkg::ROW_W-1:nfc_pkg::BLK_LSB];
  wire [nfc_pkg::BLK_LSB-1:0] pg_w = row_ff[nfc_pkg::BLK_LSB-1:0];
  wire op_pe = (op_w == nfc_pkg::OP_ERS) | (op_w == nfc_pkg::OP_PST) |
               (op_w == nfc_pkg::OP_PCF);
  wire ref_wp = op_pe & ~wp_rel_ff;
  wire ref_bad = ((op_w == nfc_pkg::OP_ERS) | (op_w == nfc_pkg::OP_PST)) & bbt_hit;
  wire ref_ord = (op_w == nfc_pkg::OP_PST) & ~pend_ff & last_vld_ff &
                 (last_blk_ff == blk_w) & (pg_w <= last_pg_ff);
  wire ref_pl = pend_ff & ~((op_w == nfc_pkg::OP_PST) | (op_w == nfc_pkg::OP_STS) |
                            (op_w == nfc_pkg::OP_RST));
  wire refuse = ref_wp | ref_bad | ref_ord | ref_pl;
  wire start = cmd_acc & ~refuse;
  wire [10:0] itm = item(op_ff, step_ff, col_ff, row_ff, stat_mode_ff, two_ff, wdat_ff);
  wire [2:0] itm_kind = itm[10:8];
  wire [7:0] itm_byte = itm[7:0];
  wire is_stat_op = (op_ff == nfc_pkg::OP_STS) | (op_ff == nfc_pkg::OP_ERS) |
                    (op_ff == nfc_pkg::OP_PCF);
  // only the status read after erase or final confirm judges the block
  wire fail_set = cap & dq_s2_ff[nfc_pkg::SB_FAIL] &
                  ((op_ff == nfc_pkg::OP_ERS) | (op_ff == nfc_pkg::OP_PCF));
  wire sw_add = wr_ok & idle & (widx == nfc_pkg::R_BAD);
  wire bbt_add = fail_set | sw_add;
  wire [nfc_pkg::BLK_W-1:0] bbt_blk = fail_set ? blk_w : avs_writedata_i[nfc_pkg::BLK_W-1:0];
  wire [7:0] hold_cyc = (kind_ff == nfc_pkg::K_DWR) ? 8'(nfc_pkg::WH_CYC) :
                        (kind_ff == nfc_pkg::K_DRD) ? 8'(nfc_pkg::RHW_CYC) :
                        8'(nfc_pkg::ADL_CYC);

  // writes stall until idle, which also holds off commands at power-up
  assign avs_waitrequest_o = (avs_write_i & ~idle) | (avs_read_i & ~rd_vld_ff);

  always_comb begin
    sts_w = '0;
    sts_w[nfc_pkg::SF_BUSY] = ~idle;
    sts_w[nfc_pkg::SF_FAIL] = fail_ff;
    sts_w[nfc_pkg::SF_REF] = refused_ff;
    sts_w[nfc_pkg::SF_NOTFF] = not_ff_ff;
    sts_w[nfc_pkg::SF_RB] = rb_s2_ff;
    sts_w[nfc_pkg::SF_PWR] = pwr_done_ff;
    sts_w[nfc_pkg::SF_PEND] = pend_ff;
    sts_w[nfc_pkg::SF_SBYTE +: 8] = sbyte_ff;
    sts_w[nfc_pkg::SF_PAR +: 8] = par_ff;
  end

  wire [31:0] rd_mux = (widx == nfc_pkg::R_CTRL) ? {30'h0, plane_sel_ff, wp_rel_ff} :
                       (widx == nfc_pkg::R_COL) ? {20'h0, col_ff} :
                       (widx == nfc_pkg::R_ROW) ? {15'h0, row_ff} :
                       (widx == nfc_pkg::R_DATA) ? {24'h0, rdat_ff} :
                       (widx == nfc_pkg::R_STAT) ? sts_w :
                       (widx == nfc_pkg::R_BAD) ? 32'(bbt_cnt) : 32'h0;

  ////////////////////////////////////////////////////////////////////////////
  // strobe sequencer
  always_comb begin
    nxt_st = st_ff;
    nxt_cnt = cnt_ff;
    nxt_step = step_ff;
    nxt_kind = kind_ff;
    nxt_ce_b = ce_b_ff;
    nxt_cle = cle_ff;
    nxt_ale = ale_ff;
    nxt_we_b = we_b_ff;
    nxt_rd_b = rd_b_ff;
    nxt_dq = dq_ff;
    nxt_oe_b = oe_b_ff;
    cap = 1'b0;
    case (st_ff)
      nfc_pkg::st_pwr: begin
        if (pwr_done_ff) nxt_st = nfc_pkg::st_idle;
      end
      nfc_pkg::st_idle: begin
        nxt_ce_b = 1'b1; // released between operations, page buffer keeps data
        nxt_oe_b = 1'b1;
        if (start) begin
          nxt_st = nfc_pkg::st_fetch;
          nxt_step = 4'h0;
        end
      end
      nfc_pkg::st_fetch: begin
        case (itm_kind)
          nfc_pkg::K_END: nxt_st = nfc_pkg::st_idle;
          nfc_pkg::K_NOP: nxt_step = step_ff + 4'h1;
          nfc_pkg::K_WRB: begin
            nxt_st = nfc_pkg::st_busy;
            nxt_cnt = 8'(nfc_pkg::WB_CYC);
          end
          default: begin
            nxt_st = nfc_pkg::st_set;
            nxt_kind = itm_kind;
            nxt_ce_b = 1'b0;
            nxt_cle = (itm_kind == nfc_pkg::K_CMD);
            nxt_ale = (itm_kind == nfc_pkg::K_ADR);
            nxt_dq = itm_byte;
            nxt_oe_b = (itm_kind == nfc_pkg::K_DRD);
            nxt_cnt = 8'(nfc_pkg::SET_CYC);
          end
        endcase
      end
      nfc_pkg::st_set: begin
        if (cnt_ff <= 8'h01) begin
          nxt_st = nfc_pkg::st_low;
          if (kind_ff == nfc_pkg::K_DRD) begin
            nxt_rd_b = 1'b0;
            nxt_cnt = 8'(nfc_pkg::RDL_CYC);
          end else begin
            nxt_we_b = 1'b0;
            nxt_cnt = 8'(nfc_pkg::WP_CYC);
          end
        end else begin
          nxt_cnt = cnt_ff - 8'h01;
        end
      end
      nfc_pkg::st_low: begin
        if (cnt_ff <= 8'h01) begin
          nxt_we_b = 1'b1; // byte latched on this rise
          nxt_rd_b = 1'b1;
          cap = (kind_ff == nfc_pkg::K_DRD);
          nxt_st = nfc_pkg::st_high;
          nxt_cnt = hold_cyc;
        end else begin
          nxt_cnt = cnt_ff - 8'h01;
        end
      end
      nfc_pkg::st_high: begin
        if (cnt_ff <= 8'h01) begin
          nxt_cle = 1'b0;
          nxt_ale = 1'b0;
          nxt_oe_b = 1'b1;
          nxt_step = step_ff + 4'h1;
          nxt_st = nfc_pkg::st_fetch;
        end else begin
          nxt_cnt = cnt_ff - 8'h01;
        end
      end
      nfc_pkg::st_busy: begin
        // nothing is issued while busy; chip select stays low through it
        if (cnt_ff != 8'h00) nxt_cnt = cnt_ff - 8'h01;
        else if (rb_s2_ff) begin
          nxt_st = nfc_pkg::st_rr;
          nxt_cnt = 8'(nfc_pkg::RR_CYC);
        end
      end
      nfc_pkg::st_rr: begin
        if (cnt_ff <= 8'h01) begin
          nxt_step = step_ff + 4'h1;
          nxt_st = nfc_pkg::st_fetch;
        end else begin
          nxt_cnt = cnt_ff - 8'h01;
        end
      end
      default: nxt_st = nfc_pkg::st_idle;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      st_ff <= nfc_pkg::st_pwr;
      cnt_ff <= 8'h00;
      step_ff <= 4'h0;
      kind_ff <= nfc_pkg::K_END;
      {ce_b_ff, cle_ff, ale_ff, we_b_ff, rd_b_ff, oe_b_ff} <= 6'h27;
      dq_ff <= 8'h00;
    end else begin
      st_ff <= nxt_st;
      cnt_ff <= nxt_cnt;
      step_ff <= nxt_step;
      kind_ff <= nxt_kind;
      {ce_b_ff, cle_ff, ale_ff, we_b_ff, rd_b_ff, oe_b_ff} <=
        {nxt_ce_b, nxt_cle, nxt_ale, nxt_we_b, nxt_rd_b, nxt_oe_b};
      dq_ff <= nxt_dq;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // synchronisers, power-up wait, bus reads
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      {rb_s1_ff, rb_s2_ff} <= 2'h0;
      {dq_s1_ff, dq_s2_ff} <= 16'h0000;
      pwr_cnt_ff <= '0;
      pwr_done_ff <= 1'b0;
      rd_vld_ff <= 1'b0;
      rdata_ff <= 32'h0;
    end else begin
      {rb_s1_ff, rb_s2_ff} <= {nand_rb_i, rb_s1_ff};
      {dq_s1_ff, dq_s2_ff} <= {nand_dq_i, dq_s1_ff};
      if (!pwr_done_ff) pwr_cnt_ff <= pwr_cnt_ff + PW'(1);
      if (pwr_cnt_ff == PW'(PWR_CYC - 1)) pwr_done_ff <= 1'b1;
      rd_vld_ff <= avs_read_i & ~rd_vld_ff;
      if (avs_read_i) rdata_ff <= rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // software registers and operation bookkeeping
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      {wp_rel_ff, plane_sel_ff, two_ff, pend_ff, stat_mode_ff} <= 5'h00;
      {fail_ff, refused_ff, not_ff_ff, last_vld_ff} <= 4'h0;
      col_ff <= '0;
      row_ff <= '0;
      {wdat_ff, rdat_ff, sbyte_ff, par_ff} <= 32'h0;
      op_ff <= nfc_pkg::OP_RST;
      last_blk_ff <= '0;
      last_pg_ff <= '0;
    end else begin
      if (wr_ok && idle && widx == nfc_pkg::R_CTRL) begin
        wp_rel_ff <= avs_writedata_i[nfc_pkg::CF_WP];
        plane_sel_ff <= avs_writedata_i[nfc_pkg::CF_PLANE];
      end
      if (wr_ok && idle && widx == nfc_pkg::R_COL) col_ff <= avs_writedata_i[nfc_pkg::COL_W-1:0];
      if (wr_ok && idle && widx == nfc_pkg::R_ROW) row_ff <= avs_writedata_i[nfc_pkg::ROW_W-1:0];
      if (wr_ok && idle && widx == nfc_pkg::R_DATA) wdat_ff <= avs_writedata_i[7:0];
      if (cmd_acc) refused_ff <= refuse;
      if (start) begin
        op_ff <= op_w;
        two_ff <= ((op_w == nfc_pkg::OP_PCF) & plane_sel_ff) |
                  ((op_w == nfc_pkg::OP_PST) & pend_ff);
        if (op_w == nfc_pkg::OP_PCF && plane_sel_ff) pend_ff <= 1'b1;
        if (op_w == nfc_pkg::OP_PST || op_w == nfc_pkg::OP_RST) pend_ff <= 1'b0;
        if (op_w == nfc_pkg::OP_PST && !pend_ff) begin
          last_vld_ff <= 1'b1;
          last_blk_ff <= blk_w;
          last_pg_ff <= pg_w;
        end
        if (op_w == nfc_pkg::OP_ERS && blk_w == last_blk_ff) last_vld_ff <= 1'b0;
        if (op_w == nfc_pkg::OP_PRD) par_ff <= 8'h00;
      end
      // a fresh failure wins over the clear from a new start
      if (fail_set) fail_ff <= 1'b1;
      else if (start) fail_ff <= 1'b0;
      if (st_ff == nfc_pkg::st_fetch && itm_kind == nfc_pkg::K_CMD)
        stat_mode_ff <= (itm_byte == nfc_pkg::C_STAT);
      if (cap) begin
        rdat_ff <= dq_s2_ff;
        if (is_stat_op) sbyte_ff <= dq_s2_ff;
        else begin
          not_ff_ff <= (dq_s2_ff != nfc_pkg::ERASED);
          par_ff <= par_ff ^ dq_s2_ff;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  nfc_bbt #(
    .DEPTH(BBT_DEPTH),
    .BW(nfc_pkg::BLK_W)
  ) u_bbt (
    .ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i),
    .add_i(bbt_add),
    .add_blk_i(bbt_blk),
    .chk_blk_i(blk_w),
    .hit_o(bbt_hit),
    .cnt_o(bbt_cnt)
  );

  assign avs_readdata_o = rdata_ff;
  assign nand_ce_b_o = ce_b_ff;
  assign nand_cle_o = cle_ff;
  assign nand_ale_o = ale_ff;
  assign nand_we_b_o = we_b_ff;
  assign read_strobe_low_o = rd_b_ff;
  assign nand_dq_o = dq_ff;
  assign nand_dq_oe_b_o = oe_b_ff;
  // protect held low through power-up and until software releases it
  assign nand_wp_b_o = wp_rel_ff & pwr_done_ff;
endmodule // nfc_host

// *** dv/nfc_host_props.sv ***
`timescale 1ns/10ps
module nfc_host_chk #(parameter int PWR_CYC = 50) (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic nand_ce_b_o,
  input wire logic nand_cle_o,
  input wire logic nand_ale_o,
  input wire logic nand_we_b_o,
  input wire logic read_strobe_low_o,
  input wire logic nand_wp_b_o,
  input wire logic nand_rb_i,
  input wire logic [7:0] nand_dq_o,
  input wire logic nand_dq_oe_b_o
);
  int pcnt_ff;
  always_ff @(posedge ref_clk_i) pcnt_ff <= !rst_b_i ? 0 : pcnt_ff + (pcnt_ff < PWR_CYC);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);
  a_pwr_quiet: assert property (pcnt_ff < PWR_CYC |-> nand_ce_b_o && !nand_wp_b_o)
    else $error("bus active during power-up wait");
  a_latch_excl: assert property (!(nand_cle_o && nand_ale_o))
    else $error("command and address latch both high");
  a_we_sel: assert property (!nand_we_b_o |-> !nand_ce_b_o)
    else $error("write strobe without chip select");
  a_we_width: assert property ($fell(nand_we_b_o) |-> !nand_we_b_o [*3] ##1 nand_we_b_o)
    else $error("write strobe width wrong");
  a_rd_mode: assert property (!read_strobe_low_o |-> !nand_cle_o && !nand_ale_o && nand_we_b_o
    && !nand_ce_b_o && nand_dq_oe_b_o)
    else $error("read strobe in wrong bus mode");
  a_rd_width: assert property ($fell(read_strobe_low_o) |-> !read_strobe_low_o [*7]
    ##1 read_strobe_low_o)
    else $error("read strobe width wrong");
  a_rd_ready: assert property ($fell(read_strobe_low_o) |-> $past(nand_rb_i, 3))
    else $error("read while device busy");
  a_wp_erase: assert property ($rose(nand_we_b_o) && nand_cle_o && nand_dq_o == 8'h60
    |-> nand_wp_b_o)
    else $error("erase issued while protected");
endmodule // nfc_host_chk
bind nfc_host nfc_host_chk #(.PWR_CYC(PWR_CYC)) chk_u (.ref_clk_i, .rst_b_i, .nand_ce_b_o,
  .nand_cle_o, .nand_ale_o, .nand_we_b_o, .read_strobe_low_o, .nand_wp_b_o, .nand_rb_i,
  .nand_dq_o, .nand_dq_oe_b_o);

// *** dv/nfc_dev_model.sv ***
`timescale 1ns/10ps
module nfc_dev_model #(
  parameter logic [10:0] BAD_BLK = 11'h015,
  parameter logic [10:0] FAIL_BLK = 11'h02a
) (
  input wire logic ce_b_i,
  input wire logic cle_i,
  input wire logic ale_i,
  input wire logic we_b_i,
  input wire logic read_strobe_low_i,
  input wire logic wp_b_i,
  input wire logic [7:0] dq_i,
  output logic rb_o,
  output logic [7:0] dq_o
);
  logic [7:0] adr [0:4];
  logic [7:0] cmd;
  logic [11:0] col;
  logic fail;
  int na;
  wire logic [10:0] blk = {adr[4][0], adr[3], adr[2][7:6]};
  initial begin
    rb_o = 1'b1;
    dq_o = 8'h5a;
    cmd = 8'hff;
    fail = 1'b0;
    na = 0;
  end
  // busy ignores all commands but status and reset; address bytes still latch
  always @(posedge we_b_i) if (!ce_b_i) begin
    if (cle_i && (rb_o || dq_i == 8'h70 || dq_i == 8'hff)) begin
      cmd = dq_i;
      na = (dq_i == 8'h60) ? 2 : 0;
      col = {adr[1][3:0], adr[0]};
      if (dq_i inside {8'h30, 8'h10, 8'h11, 8'hd0, 8'hff}) begin
        // only block FAIL_BLK fails; protect forces fail
        if (dq_i != 8'h70) fail = (dq_i != 8'h30) && (!wp_b_i || blk == FAIL_BLK);
        rb_o = 1'b0;
        rb_o <= #400 1'b1;
      end
    end else if (ale_i && na < 5) begin
      adr[na] = dq_i;
      na++;
    end
  end
  // status mode sticks until next command
  // one status byte stands for the whole page, all four sectors
  always @(negedge read_strobe_low_i) if (!ce_b_i) begin
    #5 dq_o = (cmd == 8'h70) ? {wp_b_i, rb_o, 5'h00, fail} :
      (blk == BAD_BLK && col == 12'd2048) ? 8'h00 : 8'hff;
    col++;
  end
  // released bus shows a changed value, not the last byte
  always @(posedge read_strobe_low_i) #15 dq_o = ~dq_o;
endmodule // nfc_dev_model

// *** dv/tb_nfc_host.sv ***
`timescale 1ns/10ps
module tb_nfc_host;
  logic clk = 0, rst_b = 0, rd = 0, wr = 0, rb, oe_b, ce_b, cle, ale, we_b, rs_b, wp_b, wq;
  logic [4:0] adr = 0;
  logic [31:0] wd = 0, rdat, rq;
  logic [7:0] dqo, dqd;
  logic [10:0] r;
  wire logic [7:0] dq = !oe_b ? dqo : dqd;
  int errors = 0, n_tests = 0, f;
  int bad[$];
  initial forever #2 clk = ~clk;
  nfc_host #(.PWR_CYC(50)) dut_u (.ref_clk_i(clk), .rst_b_i(rst_b), .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'hf),
    .avs_readdata_o(rq), .avs_waitrequest_o(wq), .nand_ce_b_o(ce_b), .nand_cle_o(cle),
    .nand_ale_o(ale), .nand_we_b_o(we_b), .read_strobe_low_o(rs_b), .nand_wp_b_o(wp_b),
    .nand_rb_i(rb), .nand_dq_i(dq), .nand_dq_o(dqo), .nand_dq_oe_b_o(oe_b));
  nfc_dev_model dev_u (.ce_b_i(ce_b), .cle_i(cle), .ale_i(ale), .we_b_i(we_b),
    .read_strobe_low_i(rs_b), .wp_b_i(wp_b), .dq_i(dq), .rb_o(rb), .dq_o(dqd));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // request held until waitrequest seen low at an edge
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    for (k = 0; k < 30000; k++) begin
      @(posedge clk);
      if (wq === 1'b0) break;
    end
    if (k == 30000) begin errors++; wrap_up(); end
    rdat = rq;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic poll(input int b, input logic v);
    int k;
    for (k = 0; k < 800; k++) begin
      bus(0, 5'h14, 0);
      if (rdat[b] === v) break;
    end
    if (k == 800) begin errors++; wrap_up(); end
  endtask
  task automatic op(input logic [2:0] c);
    bus(1, 5'h00, {29'h0, c});
    poll(0, 1'b0);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(35));
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    bus(0, 5'h14, 0);
    chk(rdat[5], 0);
    poll(5, 1'b1);
    $display("test powerup done");
    bus(1, 5'h04, 0);
    op(3'h5);
    chk(rdat[2], 1);
    $display("test protect done");
    bus(1, 5'h04, 1);
    r = 11'h100 | 11'($urandom);
    for (int i = 0; i < 2; i++) begin
      bus(1, 5'h08, i ? 32'd2048 : 32'($urandom % 2112));
      bus(1, 5'h0c, {15'h0, i ? 11'h015 : r, 6'h00});
      op(3'h1);
      op(3'h2);
      bus(0, 5'h10, 0);
      chk(rdat[7:0], i ? 8'h00 : 8'hff);
    end
    $display("test marker done");
    for (int i = 0; i < 2; i++) begin
      f = i;
      bus(1, 5'h0c, {15'h0, i ? 11'h02a : r, 6'h00});
      op(3'h5);
      chk(rdat[1], f);
      chk(rdat[15:8], 8'hc0 | f);
      if (f) bad.push_back(11'h02a);
    end
    bus(0, 5'h18, 0);
    chk(rdat, bad.size());
    op(3'h5);
    chk(rdat[2], 1);
    $display("test erase done");
    bus(1, 5'h0c, {15'h0, r, 6'd5});
    op(3'h7);
    bus(1, 5'h10, $urandom & 32'hff);
    op(3'h3);
    op(3'h4);
    chk(rdat[2:1], 0);
    bus(1, 5'h0c, {15'h0, r, 6'd3});
    op(3'h7);
    chk(rdat[2], 1);
    $display("test program order done");
    bus(1, 5'h18, {21'h0, r});
    bad.push_back(r);
    bus(0, 5'h18, 0);
    chk(rdat, bad.size());
    bus(1, 5'h0c, {15'h0, r, 6'd9});
    op(3'h7);
    chk(rdat[2], 1);
    bus(1, 5'h04, 3);
    bus(1, 5'h0c, 0);
    op(3'h7);
    op(3'h4);
    chk(rdat[6], 1);
    op(3'h5);
    chk(rdat[2], 1);
    op(3'h6);
    chk(rdat[15:8], 8'hc0);
    op(3'h7);
    bus(1, 5'h04, 1);
    op(3'h4);
    chk(rdat[15:8], 8'hc0);
    op(3'h2);
    bus(0, 5'h10, 0);
    chk(rdat[7:0], 8'hff);
    op(3'h0);
    chk(rdat[2:1], 0);
    $display("test two plane done");
    wrap_up();
  end
endmodule // tb_nfc_host
